// [phy_rgmii_prbs_check_regs.sv]
// rgmii fifo control, sgmii status and pattern checker register bank
//
// The strobed register port was decided locally.
`default_nettype none
module phy_rgmii_prbs_check_regs (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic irq_out,
  input wire logic [1:0] rx_thr_low_in,
  input wire logic [1:0] tx_thr_low_in,
  input wire logic speed_10_100_in,
  output logic async_fifo_skip_out,
  output logic rx_clk_delay_out,
  output logic low_latency_out,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic page_rx_in,
  input wire logic negotiation_done_in,
  input wire logic chk_valid_in,
  input wire logic [7:0] chk_data_in
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic wr_ctrl2, wr_chk, rd_chk, rd_an, wr_sts, wr_mask;
  logic snap_pulse, clear_pulse;
  assign wr_ctrl2 = reg_wr_in & (reg_addr_in == phy_regs_pkg::OFS_CTRL2);
  assign wr_chk = reg_wr_in & (reg_addr_in == phy_regs_pkg::OFS_CHK_CTRL);
  assign wr_sts = reg_wr_in & (reg_addr_in == phy_regs_pkg::OFS_IRQ_STS);
  assign wr_mask = reg_wr_in & (reg_addr_in == phy_regs_pkg::OFS_IRQ_MASK);
  assign rd_chk = reg_rd_in & (reg_addr_in == phy_regs_pkg::OFS_CHK_CTRL);
  assign rd_an = reg_rd_in & (reg_addr_in == phy_regs_pkg::OFS_AN_STS);
  // a clear also freezes, so bit 8 alone is enough
  assign snap_pulse = wr_chk & (reg_wdata_in[phy_regs_pkg::B_SNAP] | reg_wdata_in[phy_regs_pkg::B_CLR]);
  assign clear_pulse = wr_chk & reg_wdata_in[phy_regs_pkg::B_CLR];

  // ----------------------------------------
  // rgmii control
  // ----------------------------------------
  logic [4:0] ctrl2_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl2_q <= phy_regs_pkg::REG_RESET[4:0];
    end else if (wr_ctrl2) begin
      ctrl2_q <= reg_wdata_in[4:0];
    end
  end

  logic [2:0] rx_thr, tx_thr;
  assign rx_thr = {ctrl2_q[phy_regs_pkg::B_RXTHR], rx_thr_low_in};
  assign tx_thr = {ctrl2_q[phy_regs_pkg::B_TXTHR], tx_thr_low_in};
  assign async_fifo_skip_out = ctrl2_q[phy_regs_pkg::B_SKIP];

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_clk_delay_out <= 1'b0;
      low_latency_out <= 1'b0;
    end else begin
      rx_clk_delay_out <= ctrl2_q[phy_regs_pkg::B_SKIP_DLY] & speed_10_100_in;
      low_latency_out <= ctrl2_q[phy_regs_pkg::B_LOWLAT] & speed_10_100_in;
    end
  end

  // ----------------------------------------
  // sync fifos
  // ----------------------------------------
  rate_fifo u_rx_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .skip_in(async_fifo_skip_out),
    .thr_in(rx_thr),
    .wr_valid_in(rx_valid_in),
    .wr_data_in(rx_data_in),
    .wr_ready_out(rx_ready_out),
    .rd_valid_out(rx_valid_out),
    .rd_data_out(rx_data_out)
  );

  rate_fifo u_tx_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .skip_in(async_fifo_skip_out),
    .thr_in(tx_thr),
    .wr_valid_in(tx_valid_in),
    .wr_data_in(tx_data_in),
    .wr_ready_out(tx_ready_out),
    .rd_valid_out(tx_valid_out),
    .rd_data_out(tx_data_out)
  );

  // ----------------------------------------
  // sgmii negotiation status
  // ----------------------------------------
  logic page_q, done_prev_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_q <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      done_prev_q <= negotiation_done_in;
      if (page_rx_in) begin
        page_q <= 1'b1;
      end else if (rd_an) begin
        page_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // pattern checker and counters
  // ----------------------------------------
  logic chk_en_q, chk_cont_q, locked, byte_evt, err_evt, loss_evt;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chk_en_q <= 1'b0;
      chk_cont_q <= 1'b0;
    end else if (wr_chk) begin
      chk_en_q <= reg_wdata_in[phy_regs_pkg::B_EN];
      chk_cont_q <= reg_wdata_in[phy_regs_pkg::B_MODE];
    end
  end

  pattern_sync u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(chk_en_q),
    .byte_valid_in(chk_valid_in),
    .byte_data_in(chk_data_in),
    .locked_out(locked),
    .byte_out(byte_evt),
    .err_out(err_evt),
    .loss_out(loss_evt)
  );

  logic [7:0] err_cnt_q, err_snap_q;
  logic [15:0] byte_cnt_q, byte_snap_q;
  logic ovf_q, loss_q, ovf_evt;
  assign ovf_evt = byte_evt & (byte_cnt_q == phy_regs_pkg::BYTE_MAX);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_cnt_q <= phy_regs_pkg::REG_RESET[7:0];
    end else if (clear_pulse) begin
      err_cnt_q <= phy_regs_pkg::REG_RESET[7:0];
    end else if (err_evt && (chk_cont_q || err_cnt_q != phy_regs_pkg::ERR_MAX)) begin
      err_cnt_q <= err_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      byte_cnt_q <= phy_regs_pkg::REG_RESET;
    end else if (clear_pulse) begin
      byte_cnt_q <= phy_regs_pkg::REG_RESET;
    end else if (byte_evt && (chk_cont_q || !ovf_evt)) begin
      byte_cnt_q <= byte_cnt_q + 16'h0001;
    end
  end

  // software sees frozen copies, so both fields stay coherent with each other
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_snap_q <= phy_regs_pkg::REG_RESET[7:0];
      byte_snap_q <= phy_regs_pkg::REG_RESET;
    end else if (snap_pulse) begin
      err_snap_q <= err_cnt_q;
      byte_snap_q <= byte_cnt_q;
    end
  end

  // set wins over the clear command
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ovf_q <= 1'b0;
    end else if (ovf_evt) begin
      ovf_q <= 1'b1;
    end else if (clear_pulse) begin
      ovf_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      loss_q <= 1'b0;
    end else if (loss_evt) begin
      loss_q <= 1'b1;
    end else if (rd_chk && locked) begin
      loss_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [phy_regs_pkg::IRQ_W-1:0] irq_sts_q, irq_mask_q, irq_set;
  always_comb begin
    irq_set = '0;
    irq_set[phy_regs_pkg::IRQ_PAGE] = page_rx_in;
    irq_set[phy_regs_pkg::IRQ_LOSS] = loss_evt;
    irq_set[phy_regs_pkg::IRQ_OVF] = ovf_evt;
    irq_set[phy_regs_pkg::IRQ_DONE] = negotiation_done_in & ~done_prev_q;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_sts_q <= '0;
    end else begin
      irq_sts_q <= irq_set | (irq_sts_q & ~(wr_sts ? reg_wdata_in[phy_regs_pkg::IRQ_W-1:0] : '0));
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_q <= '0;
    end else if (wr_mask) begin
      irq_mask_q <= reg_wdata_in[phy_regs_pkg::IRQ_W-1:0];
    end
  end

  assign irq_out = |(irq_sts_q & irq_mask_q);

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    case (reg_addr_in)
      phy_regs_pkg::OFS_CTRL2: rd_word[4:0] = ctrl2_q;
      phy_regs_pkg::OFS_AN_STS: begin
        rd_word[phy_regs_pkg::B_PAGE] = page_q;
        rd_word[phy_regs_pkg::B_DONE] = negotiation_done_in;
      end
      phy_regs_pkg::OFS_CHK_CTRL: begin
        rd_word[phy_regs_pkg::ERR_MSB:phy_regs_pkg::ERR_LSB] = err_snap_q;
        rd_word[phy_regs_pkg::B_LOSS] = loss_q;
        rd_word[phy_regs_pkg::B_LOCK] = locked;
        rd_word[phy_regs_pkg::B_OVF] = ovf_q;
        rd_word[phy_regs_pkg::B_MODE] = chk_cont_q;
        rd_word[phy_regs_pkg::B_EN] = chk_en_q;
      end
      phy_regs_pkg::OFS_BYTE_TOT: rd_word = byte_snap_q;
      phy_regs_pkg::OFS_IRQ_STS: rd_word[phy_regs_pkg::IRQ_W-1:0] = irq_sts_q;
      phy_regs_pkg::OFS_IRQ_MASK: rd_word[phy_regs_pkg::IRQ_W-1:0] = irq_mask_q;
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_word;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  skip_write_a: assert property (wr_ctrl2 |=> async_fifo_skip_out == $past(reg_wdata_in[4]))
    else $error("fifo skip does not follow control write");
  clk_delay_a: assert property (ctrl2_q[3] && speed_10_100_in |=> rx_clk_delay_out)
    else $error("rx clock delay missing at low speed");
  low_lat_a: assert property (!speed_10_100_in |=> !low_latency_out)
    else $error("low latency active outside 10/100");
  err_sat_a: assert property (!chk_cont_q && err_cnt_q == 8'hFF && !clear_pulse |=> err_cnt_q == 8'hFF)
    else $error("single mode error count left FF");
  snap_take_a: assert property (snap_pulse |=> byte_snap_q == $past(byte_cnt_q) && err_snap_q == $past(err_cnt_q))
    else $error("snapshot not taken on lock write");
  count_clear_a: assert property (clear_pulse |=> err_cnt_q == 8'h00 && byte_cnt_q == 16'h0000)
    else $error("counters not cleared");
  loss_hold_a: assert property (loss_evt |=> loss_q ##1 (loss_q || $past(rd_chk && locked)))
    else $error("sync loss flag not latched");
  byte_sat_a: assert property (!chk_cont_q && byte_cnt_q == 16'hFFFF && !clear_pulse |=> byte_cnt_q == 16'hFFFF)
    else $error("single mode byte total left FFFF");
  ovf_set_a: assert property (ovf_evt |=> ovf_q)
    else $error("overflow flag not set");
  rd_lat_a: assert property (reg_rd_in && reg_addr_in == 8'h3A |=> reg_rdata_out == $past(byte_snap_q))
    else $error("byte total read data wrong");
  page_set_a: assert property (page_rx_in |=> page_q)
    else $error("page received bit not set");
  page_clear_a: assert property (rd_an && !page_rx_in |=> !page_q)
    else $error("page received bit not cleared by read");
  done_read_a: assert property (rd_an |=> reg_rdata_out[phy_regs_pkg::B_DONE] == $past(negotiation_done_in))
    else $error("negotiation done read wrong");
  err_inc_a: assert property (err_evt && chk_cont_q && !clear_pulse |=>
    err_cnt_q == $past(err_cnt_q) + 8'h01) else $error("error count did not advance");
  byte_inc_a: assert property (byte_evt && !ovf_evt && !clear_pulse |=>
    byte_cnt_q == $past(byte_cnt_q) + 16'h0001) else $error("byte total did not advance");
  lock_read_a: assert property (rd_chk |=> reg_rdata_out[phy_regs_pkg::B_LOCK] == $past(locked))
    else $error("lock status read wrong");
  ovf_hold_a: assert property (ovf_q && !clear_pulse |=> ovf_q)
    else $error("overflow flag dropped without clear");
  mode_write_a: assert property (wr_chk |=> chk_cont_q == $past(reg_wdata_in[phy_regs_pkg::B_MODE]))
    else $error("count mode not stored");
  enable_write_a: assert property (wr_chk |=> chk_en_q == $past(reg_wdata_in[phy_regs_pkg::B_EN]))
    else $error("checker enable not stored");
  loss_clear_a: assert property (rd_chk && locked && !loss_evt |=> !loss_q)
    else $error("sync loss not cleared by read while locked");

  lock_c: cover property (!locked ##1 locked);
  loss_c: cover property (loss_evt ##[1:20] rd_chk && locked);
  skip_c: cover property (async_fifo_skip_out && rx_valid_out);
  irq_c: cover property ($rose(irq_out));
  ovf_c: cover property (ovf_evt);
endmodule
`default_nettype wire

// [phy_regs_pkg.sv]
// shared constants for the rgmii fifo and pattern checker register bank
`default_nettype none
package phy_regs_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL2 = 8'h33;
  localparam logic [7:0] OFS_AN_STS = 8'h37;
  localparam logic [7:0] OFS_CHK_CTRL = 8'h39;
  localparam logic [7:0] OFS_BYTE_TOT = 8'h3A;
  localparam logic [7:0] OFS_IRQ_STS = 8'h3C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h3D;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int B_SKIP = 4;
  localparam int B_SKIP_DLY = 3;
  localparam int B_LOWLAT = 2;
  localparam int B_RXTHR = 1;
  localparam int B_TXTHR = 0;
  localparam int B_PAGE = 1;
  localparam int B_DONE = 0;
  localparam int B_EN = 0;
  localparam int B_MODE = 1;
  localparam int B_OVF = 2;
  localparam int B_LOCK = 4;
  localparam int B_LOSS = 5;
  localparam int B_SNAP = 7;
  localparam int B_CLR = 8;
  localparam int ERR_LSB = 7;
  localparam int ERR_MSB = 14;
  // interrupt status and mask layout
  localparam int IRQ_W = 4;
  localparam int IRQ_PAGE = 0;
  localparam int IRQ_LOSS = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_DONE = 3;
  // ----------------------------------------
  // counts and limits
  // ----------------------------------------
  localparam logic [7:0] ERR_MAX = 8'hFF;
  localparam logic [15:0] BYTE_MAX = 16'hFFFF;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  localparam logic [3:0] THR_BIAS = 4'h2;
  localparam logic [2:0] LOCK_RUN = 3'h4;
  localparam logic [2:0] LOSS_RUN = 3'h4;
  typedef enum logic [1:0] {FIFO_FILL = 2'b01, FIFO_DRAIN = 2'b10} fifo_state_t;
  typedef enum logic [1:0] {CHK_HUNT = 2'b01, CHK_LOCKED = 2'b10} chk_state_t;
endpackage
`default_nettype wire

// [rate_fifo.sv]
// eight-entry sync fifo with threshold-plus-two start level and bypass
`default_nettype none
module rate_fifo (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic skip_in,
  input wire logic [2:0] thr_in,
  input wire logic wr_valid_in,
  input wire logic [7:0] wr_data_in,
  output logic wr_ready_out,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem_q [phy_regs_pkg::FIFO_DEPTH];
  logic [phy_regs_pkg::FIFO_AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [phy_regs_pkg::FIFO_AW:0] fill_q;
  phy_regs_pkg::fifo_state_t state_q;
  logic push, pop, full;

  assign full = fill_q == 4'(phy_regs_pkg::FIFO_DEPTH);
  assign wr_ready_out = skip_in | ~full;
  assign push = wr_valid_in & ~full & ~skip_in;
  assign pop = (state_q == phy_regs_pkg::FIFO_DRAIN) & (fill_q != 4'h0) & ~skip_in;

  // storage has no reset; pointers and fill count do
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q <= '0;
    end else if (skip_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + 3'(push);
      rd_ptr_q <= rd_ptr_q + 3'(pop);
      fill_q <= fill_q + 4'(push) - 4'(pop);
    end
  end

  // reading starts once fill reaches threshold plus two, then drains to empty
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= phy_regs_pkg::FIFO_FILL;
    end else begin
      case (state_q)
        phy_regs_pkg::FIFO_FILL: begin
          if (!skip_in && fill_q >= {1'b0, thr_in} + phy_regs_pkg::THR_BIAS) begin
            state_q <= phy_regs_pkg::FIFO_DRAIN;
          end
        end
        phy_regs_pkg::FIFO_DRAIN: begin
          if (skip_in || (fill_q == 4'h1 && pop && !push) || fill_q == 4'h0) begin
            state_q <= phy_regs_pkg::FIFO_FILL;
          end
        end
        default: state_q <= phy_regs_pkg::FIFO_FILL;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= 8'h00;
    end else begin
      rd_valid_out <= skip_in ? wr_valid_in : pop;
      if (skip_in) begin
        rd_data_out <= wr_data_in;
      end else if (pop) begin
        rd_data_out <= mem_q[rd_ptr_q];
      end
    end
  end
endmodule
`default_nettype wire

// [pattern_sync.sv]
// self-synchronising prbs7 byte checker: lock, error and loss detection
`default_nettype none
module pattern_sync (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_data_in,
  output logic locked_out,
  output logic byte_out,
  output logic err_out,
  output logic loss_out
);
  phy_regs_pkg::chk_state_t state_q;
  logic [6:0] seed_q;
  logic [2:0] run_q;
  logic take, miss;

  function automatic logic [7:0] prbs_byte(input logic [6:0] s);
    logic [6:0] t;
    logic b;
    logic [7:0] r;
    t = s;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      b = t[6] ^ t[5];
      r[7-i] = b;
      t = {t[5:0], b};
    end
    return r;
  endfunction

  assign take = enable_in & byte_valid_in;
  assign miss = byte_data_in != prbs_byte(seed_q);
  assign locked_out = state_q == phy_regs_pkg::CHK_LOCKED;

  // prediction always reseeds from received bits, so a bad byte in bits 6:0 costs two
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= phy_regs_pkg::CHK_HUNT;
      seed_q <= 7'h00;
      run_q <= 3'h0;
      byte_out <= 1'b0;
      err_out <= 1'b0;
      loss_out <= 1'b0;
    end else begin
      byte_out <= take;
      err_out <= take & miss & locked_out;
      loss_out <= 1'b0;
      if (!enable_in) begin
        state_q <= phy_regs_pkg::CHK_HUNT;
        run_q <= 3'h0;
      end else if (take) begin
        seed_q <= byte_data_in[6:0];
        case (state_q)
          phy_regs_pkg::CHK_HUNT: begin
            run_q <= miss ? 3'h0 : run_q + 3'h1;
            if (!miss && run_q == phy_regs_pkg::LOCK_RUN - 3'h1) begin
              state_q <= phy_regs_pkg::CHK_LOCKED;
              run_q <= 3'h0;
            end
          end
          phy_regs_pkg::CHK_LOCKED: begin
            run_q <= miss ? run_q + 3'h1 : 3'h0;
            if (miss && run_q == phy_regs_pkg::LOSS_RUN - 3'h1) begin
              state_q <= phy_regs_pkg::CHK_HUNT;
              run_q <= 3'h0;
              loss_out <= 1'b1;
            end
          end
          default: state_q <= phy_regs_pkg::CHK_HUNT;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [mac_pattern_source.sv]
// mac-side model: pattern byte source feeding the checker stream
`default_nettype none
module mac_pattern_source (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic flip_in,
  output logic chk_valid_out,
  output logic [7:0] chk_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] state_q;
  logic [7:0] byte_d;
  // x^7+x^6+1, msb first; state is the previous byte's low seven bits
  always_comb begin
    logic [6:0] s;
    s = state_q;
    byte_d = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      byte_d[i] = s[6] ^ s[5];
      s = {s[5:0], byte_d[i]};
    end
  end
  // flipping only the msb leaves the next prediction intact: one errored byte per flip
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= 7'h7F;
      chk_valid_out <= 1'b0;
      chk_data_out <= 8'h00;
    end else if (run_in) begin
      state_q <= byte_d[6:0];
      chk_valid_out <= 1'b1;
      chk_data_out <= byte_d ^ {flip_in, 7'h00};
    end else begin
      chk_valid_out <= 1'b0;
      // idle bus toggles so a stale byte is never mistaken for data
      chk_data_out <= ~chk_data_out;
    end
  end
endmodule
`default_nettype wire

// [phy_rgmii_prbs_check_regs_tb.sv]
// self-checking bench for the rgmii fifo and pattern checker register bank
`default_nettype none
module phy_rgmii_prbs_check_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] rdata;
  logic irq;
  logic speed = 1'b0;
  logic skip, dly, lowlat;
  logic rxv = 1'b0;
  logic [7:0] rxd = 8'h00;
  logic rx_vo;
  logic [7:0] rx_do;
  logic rx_rdy, tx_rdy, tx_vo;
  logic [7:0] tx_do;
  int tx_diff = 0;
  logic page = 1'b0;
  logic neg = 1'b0;
  logic run = 1'b0;
  logic flip = 1'b0;
  logic chk_v;
  logic [7:0] chk_d;
  logic [7:0] cap [0:7];
  int ncap = 0;
  int cyc = 0;
  int fail_count = 0;
  int tests_run = 0;

  phy_rgmii_prbs_check_regs u_phy_rgmii_prbs_check_regs (
    .ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .irq_out(irq),
    .rx_thr_low_in(2'b10), .tx_thr_low_in(2'b10), .speed_10_100_in(speed),
    .async_fifo_skip_out(skip), .rx_clk_delay_out(dly), .low_latency_out(lowlat),
    .rx_valid_in(rxv), .rx_data_in(rxd), .rx_ready_out(rx_rdy), .rx_valid_out(rx_vo), .rx_data_out(rx_do),
    .tx_valid_in(rxv), .tx_data_in(rxd), .tx_ready_out(tx_rdy), .tx_valid_out(tx_vo), .tx_data_out(tx_do),
    .page_rx_in(page), .negotiation_done_in(neg), .chk_valid_in(chk_v), .chk_data_in(chk_d)
  );
  mac_pattern_source u_mac_pattern_source (
    .ref_clk_in(clk), .rst_n_in(rst_n), .run_in(run), .flip_in(flip),
    .chk_valid_out(chk_v), .chk_data_out(chk_d)
  );

  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rx_vo === 1'b1) begin
      cap[ncap[2:0]] <= rx_do;
      ncap <= ncap + 1;
    end
    // tx fifo gets the same bytes and threshold, so it must mirror rx exactly
    if (tx_vo !== rx_vo || tx_do !== rx_do || tx_rdy !== rx_rdy) begin
      tx_diff <= tx_diff + 1;
    end
  end
  // ceiling sits well above the long saturation run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    check($sformatf("reg %h", a), exp, rdata);
  endtask
  task automatic send(input int n, input logic f);
    repeat (n) begin
      @(posedge clk);
      run <= 1'b1;
      flip <= f;
    end
    @(posedge clk);
    run <= 1'b0;
    flip <= 1'b0;
  endtask
  task automatic push(input logic [7:0] d);
    @(posedge clk);
    rxv <= 1'b1;
    rxd <= d;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdc(8'h33, 16'h0000);
    rdc(8'h37, 16'h0000);
    rdc(8'h39, 16'h0000);
    rdc(8'h3A, 16'h0000);
    rdc(8'h50, 16'h0000);
    @(posedge clk);
    speed <= 1'b1;
    wr(8'h33, 16'hFFFF);
    rdc(8'h33, 16'h001F);
    repeat (2) @(posedge clk);
    check("skip", 16'h0001, {15'h0000, skip});
    check("delay", 16'h0001, {15'h0000, dly});
    check("lowlat", 16'h0001, {15'h0000, lowlat});
    // bypass: one byte passes straight through, one cycle late
    push(8'h5A);
    @(posedge clk);
    rxv <= 1'b0;
    repeat (2) @(posedge clk);
    check("bypass count", 16'h0001, 16'(ncap));
    check("bypass byte", 16'h005A, {8'h00, cap[0]});
    speed <= 1'b0;
    wr(8'h33, 16'h0000);
    repeat (2) @(posedge clk);
    check("delay off", 16'h0000, {15'h0000, dly});
    // threshold 2: three entries must not start the read side
    push(8'hA0);
    push(8'hA1);
    push(8'hA2);
    @(posedge clk);
    rxv <= 1'b0;
    repeat (6) @(posedge clk);
    check("fifo early", 16'h0001, 16'(ncap));
    push(8'hA3);
    @(posedge clk);
    rxv <= 1'b0;
    repeat (10) @(posedge clk);
    check("fifo count", 16'h0005, 16'(ncap));
    for (int i = 0; i < 4; i++) check("fifo byte", 16'h00A0 + 16'(i), {8'h00, cap[i + 1]});
    check("fifo ready", 16'h0001, {15'h0000, rx_rdy});
    check("tx fifo", 16'h0000, 16'(tx_diff));
    // negotiation status and interrupt
    wr(8'h3D, 16'h0001);
    neg <= 1'b1;
    page <= 1'b1;
    @(posedge clk);
    page <= 1'b0;
    repeat (2) @(posedge clk);
    check("irq page", 16'h0001, {15'h0000, irq});
    rdc(8'h37, 16'h0003);
    rdc(8'h37, 16'h0001);
    wr(8'h3C, 16'h000F);
    @(posedge clk);
    check("irq clear", 16'h0000, {15'h0000, irq});
    wr(8'h3D, 16'h0002);
    // continuous counting with three isolated errored bytes
    wr(8'h39, 16'h0103);
    send(8, 1'b0);
    send(1, 1'b1);
    send(3, 1'b0);
    send(1, 1'b1);
    send(3, 1'b0);
    send(1, 1'b1);
    send(4, 1'b0);
    repeat (4) @(posedge clk);
    wr(8'h39, 16'h0083);
    rdc(8'h39, 16'h0193);
    rdc(8'h3A, 16'h0015);
    wr(8'h39, 16'h0103);
    wr(8'h39, 16'h0083);
    rdc(8'h3A, 16'h0000);
    rdc(8'h39, 16'h0013);
    // four bad bytes drop lock; loss stays until relocked and read
    send(4, 1'b1);
    repeat (4) @(posedge clk);
    check("irq loss", 16'h0001, {15'h0000, irq});
    rdc(8'h39, 16'h0023);
    rdc(8'h39, 16'h0023);
    send(8, 1'b0);
    repeat (4) @(posedge clk);
    rdc(8'h39, 16'h0033);
    rdc(8'h39, 16'h0013);
    wr(8'h3C, 16'h000F);
    @(posedge clk);
    check("irq w1c", 16'h0000, {15'h0000, irq});
    // single mode: both counts saturate, overflow flagged
    wr(8'h39, 16'h0101);
    send(8, 1'b0);
    repeat (300) begin
      send(1, 1'b1);
      send(1, 1'b0);
    end
    send(65536, 1'b0);
    repeat (4) @(posedge clk);
    wr(8'h39, 16'h0081);
    rdc(8'h39, 16'h7F95);
    rdc(8'h3A, 16'hFFFF);
    report_and_stop();
  end
endmodule
`default_nettype wire
